// ### irlc_bridge_model.sv
// far side model: infrared bridge that captures remote commands
`timescale 1ns/1ps
`default_nettype none
module irlc_bridge_model
    import irlc_pkg::*;
(
    // clock and reset
    input  wire logic      i_ref_clk,
    input  wire logic      i_reset_n,
    // command strobe from the remote
    input  wire logic      i_cmd_valid,
    input  wire irlc_msg_t i_cmd,
    // captured state
    output var irlc_msg_t  o_last,
    output var logic [7:0] o_count,
    output var logic       o_load_on
);
    // a strobe lasts one cycle, so it is taken on that edge only
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_last <= '0;
            o_count <= 8'h00;
            o_load_on <= 1'h0;
        end else if (i_cmd_valid) begin
            o_last <= i_cmd;
            o_count <= o_count + 8'h01;
            if (i_cmd.cmd == IRLC_CMD_PAIR_ON_OFF) begin
                o_load_on <= 1'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ### irlc_defines.svh
// timing constants for the infrared lighting remote button logic
`ifndef IRLC_DEFINES_SVH
`define IRLC_DEFINES_SVH
`define IRLC_CLK_HZ        125000000
`define IRLC_LONG_MS       1000
`define IRLC_RESET_MS      10000
`define IRLC_ERASE_MS      5000
`define IRLC_MEDIA_MS      10000
`define IRLC_MS_CYCLES     (`IRLC_CLK_HZ / 1000)
`define IRLC_SLOW_BIT      9
`define IRLC_FAST_BIT      7
`define IRLC_VFAST_BIT     5
`define IRLC_NUM_SCEN      5
`define IRLC_FIRST_OUT     2'h1
`define IRLC_SECOND_OUT    2'h2
`endif

// ### irlc_pkg.sv
// types shared by the infrared lighting remote button logic
package irlc_pkg;
    // command codes sent toward the infrared bridge
    typedef enum logic [3:0] {
        IRLC_CMD_NONE, IRLC_CMD_GROUP_ON, IRLC_CMD_GROUP_OFF,
        IRLC_CMD_BRIGHTEN, IRLC_CMD_DIM, IRLC_CMD_ACTION,
        IRLC_CMD_SCENARIO, IRLC_CMD_PAIR_ON_OFF, IRLC_CMD_ERASE,
        IRLC_CMD_FACTORY
    } irlc_cmd_t;
    // learn indicator patterns
    typedef enum logic [2:0] {
        IRLC_LED_OFF, IRLC_LED_SLOW, IRLC_LED_FAST, IRLC_LED_VFAST,
        IRLC_LED_BLINK5
    } irlc_led_t;
    // one outgoing command with its arguments
    typedef struct packed {
        irlc_cmd_t  cmd;
        logic [2:0] index;
        logic [1:0] output_sel;
        logic       regulation;
    } irlc_msg_t;
endpackage

// ### irlc_remote.sv
// button classification, learn sequencing and media selection
//
// Overview of operation
// - left short press under 1 s sends group on, regulation on
// - right short press under 1 s sends group off, regulation off
// - left or right held over 1 s brightens or dims, regulation off
// - short press of action button sends its assigned action
// - five scenario buttons; short press launches that stored scenario
// - learn short then learn hold over 10 s restores factory, very fast LED
// - pairing a channel on button pairs its off button too
// - learn short gives slow flash, control short then gives fast flash
// - actuators flash slow, then fast with load on; far side behaviour
// - another learn short closes pairing, learn LEDs go off
// - in learn mode long left, right or action press erases control, LED blinks 5 s
// - after factory reset first channel drives output 1, second output 2
// - media window of 10 s; scenario short presses toggle; blue lit means radio
// - media close: fast flash then off when 10 s window ends
// - outside the media window, blue LED steady while scenario button held, off after release
`timescale 1ns/1ps
`default_nettype none
`include "irlc_defines.svh"
module irlc_remote
    import irlc_pkg::*;
#(
    parameter int unsigned MS_CYCLES = `IRLC_MS_CYCLES
) (
    // clock and reset
    input  wire logic       i_ref_clk,
    input  wire logic       i_reset_n,
    // raw buttons from pins, active high
    input  wire logic       i_left,
    input  wire logic       i_right,
    input  wire logic       i_action,
    input  wire logic [4:0] i_scen,
    input  wire logic       i_learn,
    // outgoing command, one-cycle strobe
    output logic            o_cmd_valid,
    output irlc_msg_t       o_cmd,
    // indicators
    output logic            o_learn_led,
    output logic            o_blue_led,
    output logic            o_media_radio
);
    // ==========================================================
    // input synchronisers
    // ==========================================================
    localparam int NB = 9;
    logic [NB-1:0] sync1;
    logic [NB-1:0] btn;
    logic [NB-1:0] btn_q;
    // pins are asynchronous to the clock, two stages before use
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sync1 <= '0;
            btn   <= '0;
            btn_q <= '0;
        end else begin
            sync1 <= {i_learn, i_scen, i_action, i_right, i_left};
            btn   <= sync1;
            btn_q <= btn;
        end
    end
    wire logic [NB-1:0] rise = btn & ~btn_q;
    wire logic [NB-1:0] fall = ~btn & btn_q;
    wire logic          learn_b = btn[8];

    // ==========================================================
    // millisecond tick and press timers
    // ==========================================================
    logic [16:0] pre;
    logic        ms_tick;
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pre <= '0;
        end else if (pre == 17'(MS_CYCLES - 1)) begin
            pre <= '0;
        end else begin
            pre <= pre + 17'h1;
        end
    end
    assign ms_tick = (pre == 17'(MS_CYCLES - 1));

    // one press timer shared by the control buttons; only one at a time
    logic [13:0] hold_ms;
    logic [13:0] learn_ms;
    logic        long_seen;
    wire logic   ctrl_any = |btn[7:0];
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            hold_ms   <= '0;
            long_seen <= 1'b0;
        end else if (|rise[7:0]) begin
            hold_ms   <= '0;
            long_seen <= 1'b0;
        end else if (ctrl_any && ms_tick && !long_seen) begin
            hold_ms <= hold_ms + 14'h1;
            // equal to threshold already counts as long
            if (hold_ms + 14'h1 >= 14'(`IRLC_LONG_MS))
                long_seen <= 1'b1;
        end
    end
    wire logic long_now = ctrl_any && ms_tick && !long_seen &&
                          (hold_ms + 14'h1 >= 14'(`IRLC_LONG_MS));

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            learn_ms <= '0;
        end else if (rise[8]) begin
            learn_ms <= '0;
        end else if (learn_b && ms_tick && learn_ms != 14'h3FFF) begin
            learn_ms <= learn_ms + 14'h1;
        end
    end

    // ==========================================================
    // learn sequencer
    // ==========================================================
    typedef enum logic [2:0] {
        S_IDLE, S_ARMED, S_PAIR, S_ERASE, S_FACTORY, S_MEDIA
    } irlc_state_t;
    irlc_state_t state;
    logic [13:0] win_ms;
    logic        radio;
    logic [2:0]  sel_idx;

    function automatic logic [2:0] first_idx(input logic [7:0] b);
        first_idx = 3'h0;
        for (int k = 7; k >= 0; k--)
            if (b[k]) first_idx = 3'(k);
    endfunction

    wire logic short_rel = (|fall[7:0]) && !long_seen;
    wire logic learn_short = fall[8] && learn_ms < 14'(`IRLC_LONG_MS);
    wire logic factory_hit = learn_b && ms_tick &&
                             learn_ms + 14'h1 == 14'(`IRLC_RESET_MS);

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state   <= S_IDLE;
            win_ms  <= '0;
            radio   <= 1'b1;
            sel_idx <= '0;
        end else begin
            if (ms_tick && win_ms != 14'h0)
                win_ms <= win_ms - 14'h1;
            case (state)
                S_IDLE: if (learn_short) state <= S_ARMED;
                S_ARMED: begin
                    if (factory_hit) begin
                        state  <= S_FACTORY;
                        win_ms <= 14'(`IRLC_ERASE_MS);
                    end else if (learn_short) begin
                        state <= S_IDLE;
                    end else if (long_now && |btn[7:3]) begin
                        // scenario long press opens media choice
                        state  <= S_MEDIA;
                        win_ms <= 14'(`IRLC_MEDIA_MS);
                    end else if (long_now) begin
                        state  <= S_ERASE;
                        win_ms <= 14'(`IRLC_ERASE_MS);
                    end else if (short_rel) begin
                        state   <= S_PAIR;
                        sel_idx <= first_idx(fall[7:0]);
                    end
                end
                S_PAIR: if (learn_short) state <= S_IDLE;
                S_ERASE: if (win_ms == 14'h0) state <= S_IDLE;
                S_FACTORY: begin
                    radio <= 1'b1;
                    if (win_ms == 14'h0) state <= S_IDLE;
                end
                S_MEDIA: begin
                    if (short_rel && |fall[7:3])
                        radio <= ~radio;
                    if (win_ms == 14'h0) state <= S_IDLE;
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    // ==========================================================
    // command generation
    // ==========================================================
    irlc_msg_t next_cmd;
    logic      next_valid;
    logic      dim_left;
    always_comb begin
        next_cmd   = '{IRLC_CMD_NONE, 3'h0, 2'h0, 1'b0};
        next_valid = 1'b0;
        dim_left   = btn[0];
        if (state == S_IDLE) begin
            if (short_rel && fall[0]) begin
                next_cmd = '{IRLC_CMD_GROUP_ON, 3'h0,
                             `IRLC_FIRST_OUT, 1'b1};
                next_valid = 1'b1;
            end else if (short_rel && fall[1]) begin
                next_cmd = '{IRLC_CMD_GROUP_OFF, 3'h0,
                             `IRLC_FIRST_OUT, 1'b0};
                next_valid = 1'b1;
            end else if (short_rel && fall[2]) begin
                next_cmd   = '{IRLC_CMD_ACTION, 3'h0,
                               `IRLC_SECOND_OUT, 1'b0};
                next_valid = 1'b1;
            end else if (short_rel && |fall[7:3]) begin
                next_cmd = '{IRLC_CMD_SCENARIO,
                             first_idx(fall[7:0]) - 3'h3, 2'h0, 1'b0};
                next_valid = 1'b1;
            end else if (long_now && |btn[1:0]) begin
                next_cmd = '{dim_left ? IRLC_CMD_BRIGHTEN : IRLC_CMD_DIM,
                             3'h0, `IRLC_FIRST_OUT, 1'b0};
                next_valid = 1'b1;
            end
        end else if (state == S_ARMED && factory_hit) begin
            next_cmd   = '{IRLC_CMD_FACTORY, 3'h0, 2'h0, 1'b0};
            next_valid = 1'b1;
        end else if (state == S_ARMED && long_now && !(|btn[7:3])) begin
            next_cmd   = '{IRLC_CMD_ERASE, first_idx(btn[7:0]), 2'h0,
                           1'b0};
            next_valid = 1'b1;
        end else if (state == S_ARMED && short_rel) begin
            // one step pairs both on and off of the channel
            next_cmd   = '{IRLC_CMD_PAIR_ON_OFF, first_idx(fall[7:0]),
                           2'h0, 1'b0};
            next_valid = 1'b1;
        end
    end
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_cmd_valid <= 1'b0;
            o_cmd       <= '{IRLC_CMD_NONE, 3'h0, 2'h0, 1'b0};
        end else begin
            o_cmd_valid <= next_valid;
            o_cmd       <= next_cmd;
        end
    end

    // ==========================================================
    // indicators
    // ==========================================================
    // flash phases count milliseconds so rates follow MS_CYCLES
    logic [9:0]  blink;
    irlc_led_t   led_mode;
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n)   blink <= '0;
        else if (ms_tick) blink <= blink + 10'h1;
    end
    always_comb begin
        case (state)
            S_ARMED:   led_mode = IRLC_LED_SLOW;
            S_PAIR:    led_mode = IRLC_LED_FAST;
            S_ERASE:   led_mode = IRLC_LED_BLINK5;
            S_FACTORY: led_mode = IRLC_LED_VFAST;
            S_MEDIA:   led_mode = IRLC_LED_FAST;
            default:   led_mode = IRLC_LED_OFF;
        endcase
    end
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_learn_led   <= 1'b0;
            o_blue_led    <= 1'b0;
            o_media_radio <= 1'b1;
        end else begin
            case (led_mode)
                IRLC_LED_SLOW:   o_learn_led <= blink[`IRLC_SLOW_BIT];
                IRLC_LED_FAST:   o_learn_led <= blink[`IRLC_FAST_BIT];
                IRLC_LED_BLINK5: o_learn_led <= blink[`IRLC_FAST_BIT];
                IRLC_LED_VFAST:  o_learn_led <= blink[`IRLC_VFAST_BIT];
                default:         o_learn_led <= 1'b0;
            endcase
            // media window shows the choice; otherwise held scenario
            if (state == S_MEDIA) o_blue_led <= radio;
            else                  o_blue_led <= |btn[7:3];
            o_media_radio <= radio;
        end
    end
endmodule
`default_nettype wire

// ### irlc_remote_asserts.sv
// port assertions for the remote button logic
`timescale 1ns/1ps
`default_nettype none
module irlc_remote_asserts
    import irlc_pkg::*;
(
    // clock and reset
    input wire logic       i_ref_clk,
    input wire logic       i_reset_n,
    // buttons
    input wire logic       i_left,
    input wire logic       i_action,
    input wire logic [4:0] i_scen,
    // outputs watched
    input wire logic       o_cmd_valid,
    input wire irlc_msg_t  o_cmd,
    input wire logic       o_blue_led
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_reset_n);
    // a command strobe must not last beyond one cycle
    a_valid_one_pulse: assert property (o_cmd_valid |=> !o_cmd_valid)
        else $error("command strobe longer than one cycle");
    a_on_regulates: assert property (o_cmd_valid
        && o_cmd.cmd == IRLC_CMD_GROUP_ON |-> o_cmd.regulation)
        else $error("group on without regulation");
    a_off_unregulates: assert property (o_cmd_valid
        && o_cmd.cmd == IRLC_CMD_GROUP_OFF |-> !o_cmd.regulation)
        else $error("group off left regulation on");
    a_dim_unregulates: assert property (o_cmd_valid && (o_cmd.cmd
        == IRLC_CMD_BRIGHTEN || o_cmd.cmd == IRLC_CMD_DIM)
        |-> !o_cmd.regulation)
        else $error("dimming left regulation on");
    a_on_from_left: assert property (o_cmd_valid
        && o_cmd.cmd == IRLC_CMD_GROUP_ON
        |-> $past(i_left, 3) || $past(i_left, 4))
        else $error("group on without a left press");
    a_action_output: assert property (o_cmd_valid
        && o_cmd.cmd == IRLC_CMD_ACTION
        |-> o_cmd.output_sel == 2'h2 && $past(i_action, 4))
        else $error("action command malformed");
    a_scen_index: assert property (o_cmd_valid
        && o_cmd.cmd == IRLC_CMD_SCENARIO |-> o_cmd.index < 3'h5)
        else $error("scenario index out of range");
    a_blue_held: assert property ((i_scen != 5'h00) [*6] |-> o_blue_led)
        else $error("blue led dark while scenario held");
endmodule
bind irlc_remote irlc_remote_asserts u_chk (.i_ref_clk, .i_reset_n,
    .i_left, .i_action, .i_scen, .o_cmd_valid, .o_cmd, .o_blue_led);
`default_nettype wire

// ### tb.sv
// self-checking bench for the remote button logic
`timescale 1ns/1ps
`default_nettype none
module tb;
    import irlc_pkg::*;
    typedef struct {
        logic [8:0] btn;
        int         hold;
        irlc_msg_t  exp;
        logic [9:0] mask;
    } irlc_row_t;
    localparam int LONG_N = 10100; // threshold is 10000 at 10 cycles/ms
    logic      clk = 1'h0;
    logic      rst_n = 1'h0;
    logic [8:0] btn = 9'h000;
    logic      valid, learn_led, blue, radio, load_on, held_blue;
    irlc_msg_t msg, last;
    logic [7:0] cnt, base;
    logic [1:0] lvl_seen;
    int        failures = 0;
    int        comparisons = 0;
    int        cycles = 0;
    irlc_row_t rows[12];
    irlc_remote #(.MS_CYCLES(10)) dut (.i_ref_clk(clk), .i_reset_n(rst_n),
        .i_left(btn[0]), .i_right(btn[1]), .i_action(btn[2]),
        .i_scen(btn[7:3]), .i_learn(btn[8]), .o_cmd_valid(valid),
        .o_cmd(msg), .o_learn_led(learn_led), .o_blue_led(blue),
        .o_media_radio(radio));
    irlc_bridge_model u_far (.i_ref_clk(clk), .i_reset_n(rst_n),
        .i_cmd_valid(valid), .i_cmd(msg), .o_last(last), .o_count(cnt),
        .o_load_on(load_on));
    // clock and hang guard
    initial begin
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        // four long holds of about 10100 cycles plus led watches
        if (cycles == 60000) begin
            failures++;
            close_out;
        end
    end
    function automatic irlc_msg_t mk(irlc_cmd_t c, logic [2:0] i,
        logic [1:0] s, logic r);
        mk = '{c, i, s, r};
    endfunction
    task automatic check(input logic [9:0] seen, input logic [9:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one press: hold n cycles, release, then let the answer settle
    task automatic press(input logic [8:0] b, input int n);
        base = cnt;
        @(posedge clk) #1 btn = b;
        repeat (n) @(posedge clk);
        #1 held_blue = blue;
        btn = 9'h000;
        repeat (20) @(posedge clk);
        #1;
    endtask
    // watch the learn led for n cycles; bit 1 high seen, bit 0 low seen
    task automatic watch(input int n, output logic [1:0] lvl);
        lvl = 2'h0;
        repeat (n) begin
            @(posedge clk);
            #1;
            if (learn_led === 1'h1) lvl[1] = 1'h1;
            if (learn_led === 1'h0) lvl[0] = 1'h1;
        end
    endtask
    task automatic close_out;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        rows[0] = '{9'h001, 50, mk(IRLC_CMD_GROUP_ON, 3'h0, 2'h1, 1'h1),
            10'h3FF};
        rows[1] = '{9'h002, 50, mk(IRLC_CMD_GROUP_OFF, 3'h0, 2'h0, 1'h0),
            10'h3C1};
        rows[2] = '{9'h004, 50, mk(IRLC_CMD_ACTION, 3'h0, 2'h2, 1'h0),
            10'h3C6};
        rows[3] = '{9'h001, LONG_N, mk(IRLC_CMD_BRIGHTEN, 3'h0, 2'h0,
            1'h0), 10'h3C1};
        rows[4] = '{9'h002, LONG_N, mk(IRLC_CMD_DIM, 3'h0, 2'h0, 1'h0),
            10'h3C1};
        for (int i = 0; i < 5; i++) begin
            rows[5 + i] = '{9'h008 << i, 50, mk(IRLC_CMD_SCENARIO,
                3'(i), 2'h0, 1'h0), 10'h3F8};
        end
        // reset values while held
        repeat (3) @(posedge clk);
        check({valid, learn_led, blue, radio}, 10'h001);
        #1 rst_n = 1'h1;
        // ordinary presses; each gives exactly one command
        for (int r = 0; r < 10; r++) begin
            press(rows[r].btn, rows[r].hold);
            check(cnt - base, 10'h001);
            check(last & rows[r].mask, rows[r].exp & rows[r].mask);
            if (rows[r].btn[7:3] != 5'h00) begin
                check({held_blue, blue}, 10'h002);
            end
        end
        // pairing: learn short, on button pairs, learn short closes
        press(9'h100, 50);
        watch(5300, lvl_seen);
        check(lvl_seen, 10'h003);
        press(9'h001, 50);
        check(last, mk(IRLC_CMD_PAIR_ON_OFF, 3'h0, 2'h0,
            1'h0));
        check(load_on, 10'h001);
        watch(2600, lvl_seen);
        check(lvl_seen, 10'h003);
        press(9'h100, 50);
        check(learn_led, 10'h000);
        press(9'h001, 50);
        check(last.cmd, IRLC_CMD_GROUP_ON);
        // media choice: learn short, long scenario hold, one toggle
        press(9'h100, 50);
        press(9'h008, LONG_N);
        check({radio, blue}, 10'h003);
        watch(2600, lvl_seen);
        check(lvl_seen, 10'h003);
        press(9'h008, 50);
        check({radio, blue}, 10'h000);
        check(cnt - base, 10'h000);
        // reset in mid-run brings the medium back to radio
        @(posedge clk) #1 rst_n = 1'h0;
        repeat (3) @(posedge clk);
        check({valid, learn_led, blue, radio}, 10'h001);
        #1 rst_n = 1'h1;
        // erase: learn short, then long control press while armed
        press(9'h100, 50);
        press(9'h001, LONG_N);
        check(cnt - base, 10'h001);
        check(last, mk(IRLC_CMD_ERASE, 3'h0, 2'h0, 1'h0));
        close_out;
    end
endmodule
`default_nettype wire
